// file: rtl/sram_burst_dev.v
// Added by the designer: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`include "sram_burst_regs.vh"

module beat_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // clock and reset
  input  wire             hclk,
  input  wire             hresetn,
  // fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data,
  // level
  output wire             full,
  output wire             empty
);
  reg [WIDTH-1:0] store [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            push;
  wire            pop;

  assign full      = (count == DEPTH[AW:0]);
  assign empty     = (count == {(AW+1){1'b0}});
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = store[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always @(posedge hclk) begin
    if (push) begin
      store[wr_ptr] <= in_data;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                   : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                   : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

module sram_burst_dev #(
  parameter DATA_W     = 36,
  parameter MASK_W     = 4,
  parameter ADDR_W     = 17,
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW    = 3
) (
  // clock and reset
  input  wire              hclk,
  input  wire              hresetn,
  // ahb-lite slave
  input  wire              hsel,
  input  wire [7:0]        haddr,
  input  wire [1:0]        htrans,
  input  wire              hwrite,
  input  wire [2:0]        hsize,
  input  wire [31:0]       hwdata,
  input  wire              hready,
  output wire              hreadyout,
  output wire              hresp,
  output reg  [31:0]       hrdata,
  // input clock phase: high in a cycle that is a K rise
  input  wire              k_rise,
  // output clock phase: high in a cycle that is a C rise
  input  wire              c_rise,
  input  wire              pll_disable_n,
  // port selects and shared address
  input  wire              write_port_select_n,
  input  wire              read_port_select_n,
  input  wire [ADDR_W-1:0] addr,
  // write data and lane masks
  input  wire [DATA_W-1:0] wdata,
  input  wire [MASK_W-1:0] byte_write_mask_n,
  output wire              write_ready,
  // read data
  output reg  [DATA_W-1:0] rdata,
  output reg               rdata_oe_n
);
  localparam LANE_W = DATA_W / MASK_W;
  localparam ENT_W  = ADDR_W + 2 + MASK_W + DATA_W;
  localparam MEM_D  = 4 << ADDR_W;

  localparam RD_IDLE  = 3'h0;
  localparam RD_WAIT  = 3'h1;
  localparam RD_ALIGN = 3'h2;
  localparam RD_BURST = 3'h3;
  localparam RD_HOLD  = 3'h4;

  // one array addressed by {group, beat}
  reg [DATA_W-1:0] mem [0:MEM_D-1];

  reg [31:0]       ctrl;
  reg [31:0]       read_count;
  reg [31:0]       write_count;
  reg              ahb_wr;
  reg [7:0]        ahb_addr;

  reg [2:0]        rd_state;
  reg [2:0]        next_rd_state;
  reg [2:0]        rd_wait;
  reg [1:0]        rd_beat;
  reg [ADDR_W-1:0] rd_addr;

  reg              wr_active;
  reg [1:0]        wr_beat;
  reg [ADDR_W-1:0] wr_addr;

  wire             single_clk;
  wire             launch_rise;
  wire             rd_start;
  wire             wr_start;
  wire             wr_beat_valid;
  wire [1:0]       wr_beat_idx;
  wire [ADDR_W-1:0] wr_beat_addr;
  wire             rd_uses_mem;
  wire             fifo_in_ready;
  wire             fifo_out_valid;
  wire             fifo_full;
  wire             fifo_empty;
  wire [ENT_W-1:0] fifo_out;
  wire [DATA_W-1:0] drain_data;
  wire [MASK_W-1:0] drain_mask_n;
  wire [1:0]       drain_beat;
  wire [ADDR_W-1:0] drain_addr;
  wire [DATA_W-1:0] merged;
  wire             drain;

  // single-clock mode launches read data on the input clock
  assign single_clk  = ctrl[`CTRL_SINGLE_CLK];
  assign launch_rise = single_clk ? k_rise : c_rise;

  // ---- ahb-lite slave, zero wait states, always okay ----
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ahb_wr   <= 1'b0;
      ahb_addr <= 8'h00;
      hrdata   <= 32'h0000_0000;
    end else begin
      ahb_wr <= 1'b0;
      if (hsel && hready && htrans[1]) begin
        ahb_wr   <= hwrite;
        ahb_addr <= haddr;
        hrdata   <= 32'h0000_0000;
        if (!hwrite) begin
          case (haddr)
            `REG_CTRL:        hrdata <= ctrl;
            `REG_STATUS:      hrdata <= {27'h0000000,
                                         fifo_empty,
                                         fifo_full,
                                         !pll_disable_n,
                                         wr_active || !fifo_empty,
                                         rd_state != RD_IDLE};
            `REG_READ_COUNT:  hrdata <= read_count;
            `REG_WRITE_COUNT: hrdata <= write_count;
            default:          hrdata <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // writes land at the end of the data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= `CTRL_RESET_VALUE;
    end else if (ahb_wr && ahb_addr == `REG_CTRL) begin
      ctrl <= {30'h00000000, hwdata[1:0]};
    end
  end

  // ---- read port ----
  // a new read is taken only once the previous burst has launched
  assign rd_start = k_rise && !read_port_select_n &&
                    (rd_state == RD_IDLE || rd_state == RD_HOLD);

  always @* begin
    next_rd_state = rd_state;
    case (rd_state)
      RD_IDLE: begin
        if (rd_start) begin
          next_rd_state = RD_WAIT;
        end
      end
      RD_WAIT: begin
        if (rd_wait == 3'h1) begin
          next_rd_state = RD_ALIGN;
        end
      end
      RD_ALIGN: begin
        if (launch_rise) begin
          next_rd_state = RD_BURST;
        end
      end
      RD_BURST: begin
        if (rd_beat == 2'h3) begin
          next_rd_state = RD_HOLD;
        end
      end
      RD_HOLD: begin
        if (rd_start) begin
          next_rd_state = RD_WAIT;
        end else if (launch_rise) begin
          next_rd_state = RD_IDLE;
        end
      end
      default: next_rd_state = RD_IDLE;
    endcase
  end

  // array read for the beat launched this cycle
  assign rd_uses_mem = (rd_state == RD_ALIGN && launch_rise) ||
                       (rd_state == RD_BURST && rd_beat != 2'h3);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_state   <= RD_IDLE;
      rd_wait    <= 3'h0;
      rd_beat    <= 2'h0;
      rd_addr    <= {ADDR_W{1'b0}};
      read_count <= 32'h0000_0000;
    end else begin
      rd_state <= next_rd_state;
      if (rd_start) begin
        rd_addr    <= addr;
        rd_beat    <= 2'h0;
        rd_wait    <= pll_disable_n ? `LAT_PLL_ON : `LAT_PLL_OFF;
        read_count <= read_count + 32'h0000_0001;
      end else begin
        if (rd_state == RD_WAIT) begin
          rd_wait <= rd_wait - 3'h1;
        end
        if (rd_uses_mem && rd_state == RD_BURST) begin
          rd_beat <= rd_beat + 2'h1;
        end
      end
    end
  end

  // read data registered; drivers off outside a burst
  always @(posedge hclk) begin
    if (rd_uses_mem) begin
      rdata <= mem[{rd_addr,
                    (rd_state == RD_ALIGN) ? 2'h0 : rd_beat + 2'h1}];
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_oe_n <= 1'b1;
    end else begin
      rdata_oe_n <= !rd_uses_mem;
    end
  end

  // ---- write port ----
  // beats offered while the fifo is full are lost
  assign wr_start = k_rise && !write_port_select_n && !wr_active &&
                    ctrl[`CTRL_WRITE_EN];
  assign wr_beat_valid = wr_start || wr_active;
  assign wr_beat_idx   = wr_start ? 2'h0 : wr_beat;
  assign wr_beat_addr  = wr_start ? addr : wr_addr;
  assign write_ready   = fifo_in_ready;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_active   <= 1'b0;
      wr_beat     <= 2'h0;
      wr_addr     <= {ADDR_W{1'b0}};
      write_count <= 32'h0000_0000;
    end else if (wr_start) begin
      wr_active   <= 1'b1;
      wr_beat     <= 2'h1;
      wr_addr     <= addr;
      write_count <= write_count + 32'h0000_0001;
    end else if (wr_active) begin
      wr_beat <= wr_beat + 2'h1;
      if (wr_beat == 2'h3) begin
        wr_active <= 1'b0;
      end
    end
  end

  // mask travels with its own data beat
  beat_fifo #(
    .WIDTH (ENT_W),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .in_valid  (wr_beat_valid),
    .in_ready  (fifo_in_ready),
    .in_data   ({wr_beat_addr, wr_beat_idx,
                 byte_write_mask_n, wdata}),
    .out_valid (fifo_out_valid),
    .out_ready (!rd_uses_mem),
    .out_data  (fifo_out),
    .full      (fifo_full),
    .empty     (fifo_empty)
  );

  assign drain_data   = fifo_out[DATA_W-1:0];
  assign drain_mask_n = fifo_out[DATA_W+MASK_W-1:DATA_W];
  assign drain_beat   = fifo_out[DATA_W+MASK_W+1:DATA_W+MASK_W];
  assign drain_addr   = fifo_out[ENT_W-1:DATA_W+MASK_W+2];
  assign drain        = fifo_out_valid && !rd_uses_mem;

  // per-lane merge: nibbles for x8, 9-bit bytes otherwise
  genvar g;
  generate
    for (g = 0; g < MASK_W; g = g + 1) begin : lane
      assign merged[g*LANE_W +: LANE_W] = drain_mask_n[g] ?
        mem[{drain_addr, drain_beat}][g*LANE_W +: LANE_W] :
        drain_data[g*LANE_W +: LANE_W];
    end
  endgenerate

  // one array port: read beats win, the drain waits
  always @(posedge hclk) begin
    if (drain) begin
      mem[{drain_addr, drain_beat}] <= merged;
    end
  end
endmodule

// file: rtl/sram_burst_regs.vh
`ifndef SRAM_BURST_REGS_VH
`define SRAM_BURST_REGS_VH

// ahb register byte offsets
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_READ_COUNT  8'h08
`define REG_WRITE_COUNT 8'h0c

// control register fields and reset value
`define CTRL_SINGLE_CLK  0
`define CTRL_WRITE_EN    1
`define CTRL_RESET_VALUE 32'h0000_0002

// status register fields
`define STAT_READ_BUSY   0
`define STAT_WRITE_BUSY  1
`define STAT_PLL_OFF     2
`define STAT_FIFO_FULL   3
`define STAT_FIFO_EMPTY  4

// burst and latency, in half clock periods (one hclk per transfer)
`define BURST_LEN        3'h4
`define LAT_PLL_ON       3'h3
`define LAT_PLL_OFF      3'h2

`endif

// file: verif/mem_ctrl_model.sv
`timescale 1ns/1ps
module mem_ctrl_model (
  // clock and reset
  input  wire hclk,
  input  wire hresetn,
  // output clock pair phased a half cycle late
  input  wire c_late,
  // clock phases
  output reg  k_rise,
  output wire c_rise
);
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      k_rise <= 1'b0;
    else
      k_rise <= ~k_rise;
  end
  assign c_rise = c_late ? ~k_rise : k_rise;
endmodule

// file: verif/sram_burst_dev_assertions.sv
`timescale 1ns/1ps
module sram_burst_dev_assertions (
  // clock and reset
  input wire        hclk,
  input wire        hresetn,
  // bus
  input wire        hsel,
  input wire [7:0]  haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire        hreadyout,
  input wire        hresp,
  input wire [31:0] hrdata,
  // memory side
  input wire        k_rise,
  input wire        read_port_select_n,
  input wire        write_ready,
  input wire        rdata_oe_n
);
  reg [3:0] since_rd;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      since_rd <= 4'hf;
    else if (k_rise && !read_port_select_n && since_rd > 4'hc)
      since_rd <= 4'h0;
    else if (since_rd != 4'hf)
      since_rd <= since_rd + 4'h1;
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence rd_start;
    k_rise && !read_port_select_n && since_rd > 4'hc;
  endsequence
  sequence four_beats;
    !rdata_oe_n [*4] ##1 rdata_oe_n;
  endsequence
  a_burst_four_beats: assert property ($fell(rdata_oe_n) |-> four_beats)
    else $error("burst length is not four");
  a_read_answers: assert property (rd_start |-> ##[2:12] $fell(rdata_oe_n))
    else $error("read start got no burst");
  a_oe_needs_read: assert property (!rdata_oe_n |-> since_rd < 4'hc)
    else $error("read data driven without a read");
  a_min_latency: assert property (rd_start |-> rdata_oe_n [*3])
    else $error("read data too early");
  a_deselect_off: assert property ($rose(rdata_oe_n) |-> rdata_oe_n [*2])
    else $error("outputs not released after burst");
  a_reset_quiet: assert property (disable iff (1'b0)
    !hresetn |-> rdata_oe_n && write_ready)
    else $error("outputs active in reset");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus response not okay");
  a_unmapped_zero: assert property (hsel && hready && htrans[1] && !hwrite
    && haddr > 8'h0c |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
endmodule

bind sram_burst_dev sram_burst_dev_assertions chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .k_rise(k_rise), .read_port_select_n(read_port_select_n),
  .write_ready(write_ready), .rdata_oe_n(rdata_oe_n));

// file: verif/dual_port_burst_sram_pins_bench.sv
`timescale 1ns/1ps
`include "sram_burst_regs.vh"
module dual_port_burst_sram_pins_bench;
  localparam [143:0] D0 = 144'h123456789_abcdef012_3456789ab_cdef01234;
  localparam [143:0] D1 = 144'h9a5c3e17b_e1d2c3b4a_5f6e7d8c9_0a1b2c3d4;
  reg         hclk, hresetn, hsel, hwrite, c_late, pll_disable_n;
  reg  [7:0]  haddr;
  reg  [1:0]  htrans;
  reg  [2:0]  hsize;
  reg  [31:0] hwdata, r;
  reg         write_port_select_n, read_port_select_n;
  reg  [16:0] addr;
  reg  [35:0] wdata;
  reg  [3:0]  byte_write_mask_n;
  wire        hreadyout, hresp, write_ready, rdata_oe_n, k_rise, c_rise;
  wire        hready;
  wire [31:0] hrdata;
  wire [35:0] rdata;
  integer     n_errors, checked;

  // single slave: its hreadyout is the bus hready
  assign hready = hreadyout;

  sram_burst_dev dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .k_rise(k_rise), .c_rise(c_rise),
    .pll_disable_n(pll_disable_n), .addr(addr), .wdata(wdata),
    .write_port_select_n(write_port_select_n),
    .read_port_select_n(read_port_select_n),
    .byte_write_mask_n(byte_write_mask_n), .write_ready(write_ready),
    .rdata(rdata), .rdata_oe_n(rdata_oe_n));
  mem_ctrl_model ctrl (.hclk(hclk), .hresetn(hresetn), .c_late(c_late),
    .k_rise(k_rise), .c_rise(c_rise));

  task summarize;
    begin
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  task check(input [35:0] got, input [35:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task step(inout integer i);
    begin
      @(posedge hclk);
      i = i + 1;
      if (i > 40) begin
        n_errors = n_errors + 1;
        summarize;
      end
    end
  endtask
  task ahb(input wr, input [7:0] a, input [31:0] wd, output [31:0] rd);
    integer i;
    begin
      i = 0;
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= wr;
      do step(i); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do step(i); while (hready !== 1'b1);
      rd = hrdata;
    end
  endtask
  // leaves the bench one edge before a K rise
  task sync_k;
    integer i;
    begin
      i = 0;
      do step(i); while (k_rise !== 1'b0);
    end
  endtask
  task drain;
    integer i;
    begin
      i = 0;
      r = 32'h2;
      while (r[`STAT_WRITE_BUSY] !== 1'b0 && i < 20) begin
        ahb(1'b0, `REG_STATUS, 32'h0, r);
        i = i + 1;
      end
      check(r[`STAT_WRITE_BUSY], 36'h0);
    end
  endtask
  task wr_burst(input sel_n, input [16:0] a, input [143:0] d,
                input [15:0] m);
    integer b;
    begin
      sync_k;
      write_port_select_n <= sel_n;
      addr <= a;
      for (b = 0; b < 4; b = b + 1) begin
        wdata <= d[b*36 +: 36];
        byte_write_mask_n <= m[b*4 +: 4];
        @(posedge hclk);
        write_port_select_n <= 1'b1;
        addr <= ~a;
      end
      wdata <= ~wdata;
      byte_write_mask_n <= 4'hf;
      drain;
    end
  endtask
  // lat: loop index of the edge that launches beat 0
  task rd_burst(input sel_n, input [16:0] a, input [143:0] e,
                input [3:0] lat);
    integer i, n, first;
    begin
      sync_k;
      read_port_select_n <= sel_n;
      addr <= a;
      @(posedge hclk);
      read_port_select_n <= 1'b1;
      addr <= ~a;
      n = 0;
      first = 15;
      for (i = 0; i < 16; i = i + 1) begin
        @(posedge hclk);
        #1;
        if (rdata_oe_n === 1'b0) begin
          if (n == 0)
            first = i;
          if (n < 4)
            check(rdata, e[n*36 +: 36]);
          n = n + 1;
        end
      end
      check(n, sel_n ? 36'h0 : 36'h4);
      if (!sel_n)
        check(first, lat);
      @(posedge hclk);
    end
  endtask
  function [143:0] merge(input [143:0] o, input [143:0] n,
                         input [15:0] m);
    integer k;
    begin
      merge = o;
      for (k = 0; k < 16; k = k + 1)
        if (!m[k])
          merge[k*9 +: 9] = n[k*9 +: 9];
    end
  endfunction

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  initial begin
    {n_errors, checked} = 64'h0;
    {hsel, hwrite, c_late} = 3'h0;
    hresetn = 1'b1;
    pll_disable_n = 1'b1;
    {write_port_select_n, read_port_select_n} = 2'h3;
    {haddr, htrans, hwdata, addr, wdata} = 95'h0;
    hsize = 3'h2;
    byte_write_mask_n = 4'hf;
    // clean falling edge so every flop with an async reset sees the reset
    #10;
    hresetn = 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, `REG_CTRL, 32'h0, r);
    check(r, `CTRL_RESET_VALUE);
    ahb(1'b1, `REG_STATUS, 32'hffff_ffff, r);
    ahb(1'b0, `REG_STATUS, 32'h0, r);
    check(r[4:0], 36'h10);
    ahb(1'b0, 8'h40, 32'h0, r);
    check(r, 36'h0);
    wr_burst(1'b0, 17'h5, D0, 16'h0);
    rd_burst(1'b0, 17'h5, D0, 4'h3);
    wr_burst(1'b0, 17'h5, D1, 16'h7bde);
    rd_burst(1'b0, 17'h5, merge(D0, D1, 16'h7bde), 4'h3);
    wr_burst(1'b1, 17'h5, D0, 16'h0);
    rd_burst(1'b0, 17'h5, merge(D0, D1, 16'h7bde), 4'h3);
    rd_burst(1'b1, 17'h9, D1, 4'h0);
    // late output clock: three waits, then two edges to its rise
    c_late <= 1'b1;
    rd_burst(1'b0, 17'h5, merge(D0, D1, 16'h7bde), 4'h4);
    pll_disable_n <= 1'b0;
    ahb(1'b0, `REG_STATUS, 32'h0, r);
    check(r[`STAT_PLL_OFF], 36'h1);
    // legacy latency: two waits, output clock rises at once
    rd_burst(1'b0, 17'h5, merge(D0, D1, 16'h7bde), 4'h2);
    ahb(1'b1, `REG_CTRL, 32'h3, r);
    rd_burst(1'b0, 17'h5, merge(D0, D1, 16'h7bde), 4'h3);
    ahb(1'b0, `REG_READ_COUNT, 32'h0, r);
    check(r, 36'h6);
    ahb(1'b0, `REG_WRITE_COUNT, 32'h0, r);
    check(r, 36'h2);
    summarize;
  end
endmodule
